// [rtl/tsr_pkg.sv]
/*
 Shared constants and types for the thermal sensor register block.
 Assumes a single 250 MHz core clock and a command-level port from an SMBus slave engine.
*/
// Behaviour
// - Reading is sign bit plus seven-bit magnitude
// - Above 127 saturates; below zero down to -127
// - High and low limits, separate read/write commands
// - Result at or past limit sets alarm flag
// - Flags sticky; status read clears unless persisting
// - Status bit 7 shows conversion busy
// - Bits 4/3 high/low alarm; bits 6, 5, 1, 0 reserved
// - Status bit 2 flags open diode
// - Unmasked threshold fault asserts open-drain alert
// - Config bit 6 stops converting, standby
// - Standby still honours one-shot command
// - Bit 6 clear gives timed auto-convert
// - Config bit 7 masks alert; reserved bits
// - Mask write never releases asserted alert
// - Masked device may ignore alert response query
// - Rate register times auto-convert only
// - Rate codes 0..7 give 1/16..8 Hz
// - Rate register resets to code 02h
// - Actual rate within thirty percent nominal
// - Command codes decoded per fixed table
// - One-shot ignored when busy or auto
// - Reset values of reading, limits, command pointer
// - Alert released after status then ARA read
package tsr_pkg;

  // Command codes
  localparam logic [7:0] CMD_RESERVED   = 8'h00;
  localparam logic [7:0] CMD_TEMP_RD    = 8'h01;
  localparam logic [7:0] CMD_STATUS_RD  = 8'h02;
  localparam logic [7:0] CMD_CONFIG_RD  = 8'h03;
  localparam logic [7:0] CMD_RATE_RD    = 8'h04;
  localparam logic [7:0] CMD_HIGH_RD    = 8'h07;
  localparam logic [7:0] CMD_LOW_RD     = 8'h08;
  localparam logic [7:0] CMD_CONFIG_WR  = 8'h09;
  localparam logic [7:0] CMD_RATE_WR    = 8'h0A;
  localparam logic [7:0] CMD_HIGH_WR    = 8'h0D;
  localparam logic [7:0] CMD_LOW_WR     = 8'h0E;
  localparam logic [7:0] CMD_ONE_SHOT   = 8'h0F;

  // Reset values
  localparam logic [7:0] TEMP_RESET     = 8'h00;
  localparam logic [7:0] HIGH_RESET     = 8'h7F;
  localparam logic [7:0] LOW_RESET      = 8'hC9;
  localparam logic [7:0] RATE_RESET     = 8'h02;
  localparam logic [1:0] CONFIG_RESET   = 2'h0;

  // Field positions
  localparam int STAT_BUSY_BIT  = 7;
  localparam int STAT_HIGH_BIT  = 4;
  localparam int STAT_LOW_BIT   = 3;
  localparam int STAT_OPEN_BIT  = 2;
  localparam int CFG_MASK_BIT   = 7;
  localparam int CFG_STOP_BIT   = 6;

  // Saturation bounds and rate decode
  localparam logic [7:0] MAG_MAX        = 8'h7F;
  localparam logic [7:0] RATE_MAX_CODE  = 8'h07;
  localparam int         RATE_TOP_SHIFT = 7;

  // Base tick of the fastest rate (8 Hz)
  localparam longint TICK_PERIOD_NS = 125000000;
  localparam longint CLK_PERIOD_NS  = 4;
  localparam int     TICK_CYCLES    = int'(TICK_PERIOD_NS / CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    TSR_WRITE_BYTE = 3'h0,
    TSR_READ_BYTE  = 3'h1,
    TSR_SEND_BYTE  = 3'h2,
    TSR_RECV_BYTE  = 3'h3,
    TSR_ARA        = 3'h4
  } tsr_kind_t;

  typedef struct packed {
    tsr_kind_t  kind;
    logic [7:0] cmd;
    logic [7:0] data;
  } tsr_txn_t;

  typedef enum logic {
    TSR_IDLE = 1'b0,
    TSR_CONV = 1'b1
  } tsr_state_t;

endpackage : tsr_pkg

// [rtl/tsr_thermal_regs.sv]
/*
 Register set, alarm logic and conversion control of the thermal sensor.
 Assumes the SMBus slave engine delivers decoded transactions on core_clk and
 the analog front end signals results with a toggle; its lines are asynchronous.
*/
`timescale 1ns/10ps
`default_nettype none

module tsr_thermal_regs #(
  parameter int            TICK_CYCLES = tsr_pkg::TICK_CYCLES,
  parameter int            RAW_WIDTH   = 10,
  parameter logic [6:0]    DEV_ADDR    = 7'h2A  // Arbitrary value
) (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  // Transactions from the SMBus engine
  input  wire logic                 txnValid,
  input  wire tsr_pkg::tsr_txn_t    txn,
  output logic                      rdValid,
  output logic [7:0]                rdData,
  output logic                      araAck,
  // Analog front end
  output logic                      convStart,
  input  wire logic                 convDoneTgl,
  input  wire logic [RAW_WIDTH-1:0] rawTemp,
  input  wire logic                 openDiode,
  // Open-drain alert pin
  output logic                      alertOutN,
  output logic                      alertOe
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] saturate(input logic signed [RAW_WIDTH-1:0] raw);
    logic signed [RAW_WIDTH-1:0] neg;
    neg = -raw;
    if (raw > $signed({{(RAW_WIDTH-8){1'b0}}, tsr_pkg::MAG_MAX}))
      saturate = tsr_pkg::MAG_MAX;
    else if (raw >= 0)
      saturate = {1'b0, raw[6:0]};
    else if (neg > $signed({{(RAW_WIDTH-8){1'b0}}, tsr_pkg::MAG_MAX}) || neg < 0)
      saturate = {1'b1, tsr_pkg::MAG_MAX[6:0]};
    else
      saturate = {1'b1, neg[6:0]};
  endfunction : saturate

  function automatic logic signed [8:0] toSigned(input logic [7:0] sm);
    toSigned = sm[7] ? -$signed({2'b00, sm[6:0]}) : $signed({2'b00, sm[6:0]});
  endfunction : toSigned

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rstSync1;
  logic rstSyncN;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rstSync1 <= 1'b0;
      rstSyncN <= 1'b0;
    end else begin
      rstSync1 <= 1'b1;
      rstSyncN <= rstSync1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Front-end synchronisers
  logic                 doneS1, doneS2, doneS3;
  logic                 openS1, openS2;
  logic [RAW_WIDTH-1:0] rawS1, rawS2;
  logic                 doneEvt;

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      doneS1 <= 1'b0;
      doneS2 <= 1'b0;
      doneS3 <= 1'b0;
      openS1 <= 1'b0;
      openS2 <= 1'b0;
      rawS1  <= '0;
      rawS2  <= '0;
    end else begin
      doneS1 <= convDoneTgl;
      doneS2 <= doneS1;
      doneS3 <= doneS2;
      openS1 <= openDiode;
      openS2 <= openS1;
      rawS1  <= rawTemp;
      rawS2  <= rawS1;
    end
  end

  assign doneEvt = doneS2 ^ doneS3;

  ////////////////////////////////////////////////////////////////////////////
  // Transaction decode
  logic [7:0] cmdPtr;
  logic       isWrite, isRead, isRecv, isSend, isAra;
  logic [7:0] readSel;

  assign isWrite = txnValid && txn.kind == tsr_pkg::TSR_WRITE_BYTE;
  assign isRead  = txnValid && txn.kind == tsr_pkg::TSR_READ_BYTE;
  assign isRecv  = txnValid && txn.kind == tsr_pkg::TSR_RECV_BYTE;
  assign isSend  = txnValid && txn.kind == tsr_pkg::TSR_SEND_BYTE;
  assign isAra   = txnValid && txn.kind == tsr_pkg::TSR_ARA;
  assign readSel = isRead ? txn.cmd : cmdPtr;

  logic [7:0] temperature_reading;
  logic [7:0] high_limit;
  logic [7:0] low_limit;
  logic [7:0] conversion_rate;
  logic       cfgMask, cfgStop;
  logic       high_alarm_flag, low_alarm_flag, openFlag;
  logic       highCond, lowCond;
  tsr_pkg::tsr_state_t state;
  logic       statusRd;

  assign statusRd = (isRead || isRecv) && readSel == tsr_pkg::CMD_STATUS_RD;

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN)
      cmdPtr <= tsr_pkg::CMD_RESERVED;
    else if (isRead)
      cmdPtr <= txn.cmd;
  end

  // Limits, rate and configuration
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      high_limit      <= tsr_pkg::HIGH_RESET;
      low_limit       <= tsr_pkg::LOW_RESET;
      conversion_rate <= tsr_pkg::RATE_RESET;
      {cfgMask, cfgStop} <= tsr_pkg::CONFIG_RESET;
    end else if (isWrite) begin
      case (txn.cmd)
        tsr_pkg::CMD_HIGH_WR:   high_limit      <= txn.data;
        tsr_pkg::CMD_LOW_WR:    low_limit       <= txn.data;
        tsr_pkg::CMD_RATE_WR:   conversion_rate <= txn.data;
        tsr_pkg::CMD_CONFIG_WR: begin
          cfgMask <= txn.data[tsr_pkg::CFG_MASK_BIT];
          cfgStop <= txn.data[tsr_pkg::CFG_STOP_BIT];
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interval timer: 8 Hz base tick, then 2^(7-code) ticks per conversion
  logic [31:0] preCnt;
  logic [7:0]  intCnt;
  logic [7:0]  intLen;
  logic        baseTick, autoDue, stopPrev;

  // Reserved rate codes fall back to the reset rate
  function automatic logic [2:0] RATE_TOP_SHIFT_SEL(input logic [7:0] code);
    logic [7:0] c;
    c = (code > tsr_pkg::RATE_MAX_CODE) ? tsr_pkg::RATE_RESET : code;
    RATE_TOP_SHIFT_SEL = 3'(tsr_pkg::RATE_TOP_SHIFT) - c[2:0];
  endfunction : RATE_TOP_SHIFT_SEL

  assign intLen   = 8'h01 << (RATE_TOP_SHIFT_SEL(conversion_rate));
  assign baseTick = preCnt == 32'(TICK_CYCLES - 1);

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      preCnt   <= '0;
      intCnt   <= '0;
      stopPrev <= 1'b0;
      autoDue  <= 1'b0;
    end else begin
      stopPrev <= cfgStop;
      autoDue  <= 1'b0;
      if (cfgStop || stopPrev) begin
        preCnt <= '0;
        intCnt <= '0;
      end else if (baseTick) begin
        preCnt <= '0;
        if (intCnt >= intLen - 8'h01) begin
          intCnt  <= '0;
          autoDue <= 1'b1;
        end else begin
          intCnt <= intCnt + 8'h01;
        end
      end else begin
        preCnt <= preCnt + 32'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion control
  logic oneShot;
  logic oneShotRun;

  assign oneShot = isSend && txn.cmd == tsr_pkg::CMD_ONE_SHOT
                   && cfgStop && state == tsr_pkg::TSR_IDLE;

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      state     <= tsr_pkg::TSR_IDLE;
      convStart <= 1'b0;
    end else begin
      convStart <= 1'b0;
      case (state)
        tsr_pkg::TSR_IDLE: begin
          if (oneShot || (autoDue && !cfgStop)) begin
            state     <= tsr_pkg::TSR_CONV;
            convStart <= 1'b1;
          end
        end
        tsr_pkg::TSR_CONV: begin
          // Stop aborts at once; a late result is dropped
          if (doneEvt || (cfgStop && !stopPrev && !oneShotRun))
            state <= tsr_pkg::TSR_IDLE;
        end
        default: state <= tsr_pkg::TSR_IDLE;
      endcase
    end
  end

  // Marks a standby one-shot so the stop edge does not abort it
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN)
      oneShotRun <= 1'b0;
    else if (oneShot)
      oneShotRun <= 1'b1;
    else if (state == tsr_pkg::TSR_IDLE)
      oneShotRun <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result, comparison and sticky flags
  logic       resultEvt;
  logic [7:0] newTemp;

  assign resultEvt = doneEvt && state == tsr_pkg::TSR_CONV;
  assign newTemp   = saturate(rawS2);

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      temperature_reading <= tsr_pkg::TEMP_RESET;
      highCond            <= 1'b0;
      lowCond             <= 1'b0;
    end else if (resultEvt) begin
      temperature_reading <= newTemp;
      highCond <= toSigned(newTemp) >= toSigned(high_limit);
      lowCond  <= toSigned(newTemp) <= toSigned(low_limit);
    end
  end

  logic newHigh, newLow;

  assign newHigh = resultEvt && toSigned(newTemp) >= toSigned(high_limit);
  assign newLow  = resultEvt && toSigned(newTemp) <= toSigned(low_limit);

  // New events win over the clearing read
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      high_alarm_flag <= 1'b0;
      low_alarm_flag  <= 1'b0;
      openFlag        <= 1'b0;
    end else begin
      high_alarm_flag <= (statusRd ? highCond : high_alarm_flag) | newHigh;
      low_alarm_flag  <= (statusRd ? lowCond : low_alarm_flag) | newLow;
      openFlag        <= (statusRd ? 1'b0 : openFlag) | openS2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alert latch and alert response
  logic alertLatched, statusSeen, faultNow, araTake;

  assign faultNow = highCond | lowCond | openS2;
  assign araTake  = isAra && alertLatched && !cfgMask;

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      alertLatched <= 1'b0;
      statusSeen   <= 1'b0;
    end else begin
      if (statusRd)
        statusSeen <= 1'b1;
      else if (araTake)
        statusSeen <= 1'b0;
      // Mask gates new alerts and the ARA release; it never releases the latch
      if ((newHigh || newLow || openS2) && !cfgMask)
        alertLatched <= 1'b1;
      else if (araTake && statusSeen && !faultNow)
        alertLatched <= 1'b0;
    end
  end

  assign alertOe   = alertLatched;
  assign alertOutN = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Read data path; undefined and write-only codes return zero
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      rdValid <= 1'b0;
      rdData  <= 8'h00;
      araAck  <= 1'b0;
    end else begin
      rdValid <= isRead || isRecv || isAra;
      araAck  <= araTake;
      if (isAra)
        rdData <= {DEV_ADDR, 1'b0};
      else if (isRead || isRecv) begin
        case (readSel)
          tsr_pkg::CMD_TEMP_RD:   rdData <= temperature_reading;
          tsr_pkg::CMD_STATUS_RD: rdData <= {state == tsr_pkg::TSR_CONV, 2'b00,
                                             high_alarm_flag, low_alarm_flag,
                                             openFlag, 2'b00};
          tsr_pkg::CMD_CONFIG_RD: rdData <= {cfgMask, cfgStop, 6'h00};
          tsr_pkg::CMD_RATE_RD:   rdData <= conversion_rate;
          tsr_pkg::CMD_HIGH_RD:   rdData <= high_limit;
          tsr_pkg::CMD_LOW_RD:    rdData <= low_limit;
          default:                rdData <= 8'h00;
        endcase
      end
    end
  end

endmodule : tsr_thermal_regs

`default_nettype wire

// [sim/tsr_front_model.sv]
/*
 Behavioural analog front end: answers each convStart with a result toggle.
 Assumes the bench sets the temperature and the lag before each conversion.
*/
`timescale 1ns/10ps
`default_nettype none

module tsr_front_model (
  // Clock
  input  wire logic       core_clk,
  // Conversion request and result
  input  wire logic       convStart,
  input  wire logic [9:0] tempIn,
  input  wire logic [7:0] lag,
  output logic            convDoneTgl,
  output logic [9:0]      rawTemp
);
  initial begin
    convDoneTgl = 1'b0;
    rawTemp     = 10'h000;
    forever begin
      @(posedge core_clk);
      if (convStart === 1'b1) begin
        // Inverse value while the result is not settled
        rawTemp <= ~tempIn;
        repeat (lag) @(posedge core_clk);
        rawTemp <= tempIn;
        // Stable for four clocks before the toggle
        repeat (4) @(posedge core_clk);
        convDoneTgl <= ~convDoneTgl;
      end
    end
  end
endmodule : tsr_front_model
`default_nettype wire

// [sim/tsr_thermal_regs_properties.sv]
/*
 Port checker of the thermal register block.
 Assumes it is bound onto tsr_thermal_regs and sees its ports only.
*/
`timescale 1ns/10ps
`default_nettype none

module tsr_regs_props #(
  parameter logic [6:0] DEV_ADDR = 7'h2A  // Arbitrary value
) (
  // Clock and reset
  input wire logic              core_clk,
  input wire logic              rstn,
  // Ports watched
  input wire logic              txnValid,
  input wire tsr_pkg::tsr_txn_t txn,
  input wire logic              rdValid,
  input wire logic [7:0]        rdData,
  input wire logic              araAck,
  input wire logic              convStart,
  input wire logic              alertOutN,
  input wire logic              alertOe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic isRd;
  logic statRd;
  assign isRd   = txnValid && (txn.kind inside {tsr_pkg::TSR_READ_BYTE,
                  tsr_pkg::TSR_RECV_BYTE, tsr_pkg::TSR_ARA});
  assign statRd = txnValid && txn.kind == tsr_pkg::TSR_READ_BYTE
                  && txn.cmd == tsr_pkg::CMD_STATUS_RD;
  ////////////////////////////////////////////////////////////////////////////
  property p_rd_answer; isRd |=> rdValid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_rd_cause; rdValid |-> $past(isRd); endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("answer without read");
  property p_rd_hold; !rdValid |-> $stable(rdData); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_ara_addr;
    araAck |-> rdValid && rdData == {DEV_ADDR, 1'b0} && $past(alertOe);
  endproperty
  a_ara_addr: assert property (p_ara_addr) else $error("bad alert answer");
  property p_release; $fell(alertOe) |-> $past(txnValid && txn.kind == tsr_pkg::TSR_ARA);
  endproperty
  a_release: assert property (p_release) else $error("alert freed early");
  property p_mask_keeps;
    alertOe && txnValid && txn.kind == tsr_pkg::TSR_WRITE_BYTE
    && txn.cmd == tsr_pkg::CMD_CONFIG_WR |=> alertOe ##1
    (alertOe || $past(txnValid && txn.kind == tsr_pkg::TSR_ARA));
  endproperty
  a_mask_keeps: assert property (p_mask_keeps) else $error("mask freed alert");
  property p_drive_low; alertOutN == 1'b0; endproperty
  a_drive_low: assert property (p_drive_low) else $error("alert pin high");
  property p_start_pulse; convStart |=> !convStart; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("long start");
  property p_busy; statRd && $past(convStart, 3) |=> rdData[7]; endproperty
  a_busy: assert property (p_busy) else $error("busy bit clear");
endmodule : tsr_regs_props

bind tsr_thermal_regs tsr_regs_props #(.DEV_ADDR(DEV_ADDR)) tsr_regs_props_inst (
  .core_clk, .rstn, .txnValid, .txn, .rdValid, .rdData, .araAck, .convStart,
  .alertOutN, .alertOe);
`default_nettype wire

// [sim/tsr_thermal_regs_tb.sv]
/*
 Self-checking bench of the thermal register block with a front end model.
 Assumes a shortened tick so every rate code fits in a short run.
*/
`timescale 1ns/10ps
`default_nettype none

module tsr_thermal_regs_tb;
  localparam int TICK = 20;
  localparam logic [7:0] RSV [12] = '{8'h00, 8'h05, 8'h06, 8'h0B, 8'h0C, 8'h09,
                                     8'h0A, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'hFF};
  localparam int TEMPS [8] = '{200, 127, 50, 1, 0, -5, -127, -300};
  logic              core_clk, rstn, txnValid, rdValid, araAck, convStart;
  logic              convDoneTgl, openDiode, alertOutN, alertOe;
  tsr_pkg::tsr_txn_t txn;
  logic [7:0]        rdData, lag, d;
  logic [9:0]        rawTemp, tempIn;
  logic [17:0]       e;
  logic [17:0]       expQ [$];
  int                n_mismatch, n_checks, starts, s0, w, n;

  tsr_thermal_regs #(.TICK_CYCLES(TICK), .DEV_ADDR(7'h35)) tsr_thermal_regs_inst (
    .core_clk(core_clk), .rstn(rstn), .txnValid(txnValid), .txn(txn),
    .rdValid(rdValid), .rdData(rdData), .araAck(araAck), .convStart(convStart),
    .convDoneTgl(convDoneTgl), .rawTemp(rawTemp), .openDiode(openDiode),
    .alertOutN(alertOutN), .alertOe(alertOe));
  tsr_front_model tsr_front_model_inst (.core_clk(core_clk), .convStart(convStart),
    .tempIn(tempIn), .lag(lag), .convDoneTgl(convDoneTgl), .rawTemp(rawTemp));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results

  // Answers are settled at the falling edge
  always @(negedge core_clk) begin
    if (convStart === 1'b1) starts++;
    if (rdValid === 1'b1) begin
      if (expQ.size() == 0) check(9'h000, 9'h1FF);
      else begin
        e = expQ.pop_front();
        check({araAck, rdData} & e[17:9], e[8:0]);
      end
    end
  end

  task automatic txnDo(input tsr_pkg::tsr_kind_t k, input logic [7:0] c,
                       input logic [7:0] dt);
    @(posedge core_clk);
    txnValid <= 1'b1;
    txn      <= '{kind: k, cmd: c, data: dt};
    @(posedge core_clk);
    txnValid <= 1'b0;
  endtask : txnDo

  task automatic rdK(input tsr_pkg::tsr_kind_t k, input logic [7:0] c,
                     input logic [8:0] ex, input logic [8:0] m);
    expQ.push_back({m, ex});
    txnDo(k, c, 8'h00);
  endtask : rdK

  task automatic rd(input logic [7:0] c, input logic [7:0] ex);
    rdK(tsr_pkg::TSR_READ_BYTE, c, {1'b0, ex}, 9'h1FF);
  endtask : rd

  // Reserved status bits and busy are left out
  task automatic stat(input logic [7:0] ex);
    rdK(tsr_pkg::TSR_READ_BYTE, 8'h02, {1'b0, ex}, 9'h11C);
  endtask : stat

  task automatic wr(input logic [7:0] c, input logic [7:0] dt);
    txnDo(tsr_pkg::TSR_WRITE_BYTE, c, dt);
  endtask : wr

  task automatic conv(input int t);
    tempIn <= 10'(t);
    lag    <= 8'($urandom_range(4, 12));
    txnDo(tsr_pkg::TSR_SEND_BYTE, 8'h0F, 8'h00);
    repeat (30) @(posedge core_clk);
  endtask : conv

  function automatic logic [7:0] sm(input int t);
    if (t > 127) return 8'h7F;
    if (t >= 0) return 8'(t);
    if (t < -127) return 8'hFF;
    return {1'b1, 7'(-t)};
  endfunction : sm

  initial begin
    repeat (60000) @(posedge core_clk);
    n_mismatch++;
    results();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(97));
    rstn = 1'b0; txnValid = 1'b0; txn = '0; openDiode = 1'b0;
    tempIn = 10'h000; lag = 8'h06;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    rdK(tsr_pkg::TSR_RECV_BYTE, 8'h00, 9'h000, 9'h1FF);
    rd(8'h01, 8'h00);
    rd(8'h07, 8'h7F);
    rd(8'h08, 8'hC9);
    rd(8'h04, 8'h02);
    rdK(tsr_pkg::TSR_READ_BYTE, 8'h03, 9'h000, 9'h1C0);
    stat(8'h00);
    foreach (RSV[i]) rd(RSV[i], 8'h00);
    $display("reset values done");
    // Standby before any auto interval can run out
    wr(8'h09, 8'h40);
    d = 8'($urandom_range(64, 126));
    wr(8'h0D, d);
    rd(8'h07, d);
    d = {1'b1, 7'($urandom_range(1, 127))};
    wr(8'h0E, d);
    rd(8'h08, d);
    wr(8'h0A, 8'h05);
    rd(8'h04, 8'h05);
    wr(8'h01, 8'h55);
    rd(8'h01, 8'h00);
    rdK(tsr_pkg::TSR_RECV_BYTE, 8'h00, 9'h000, 9'h1FF);
    $display("register access done");
    s0 = starts;
    repeat (700) @(posedge core_clk);
    check(9'(starts - s0), 9'h000);
    foreach (TEMPS[i]) begin
      conv(TEMPS[i]);
      rd(8'h01, sm(TEMPS[i]));
    end
    s0 = starts;
    lag <= 8'd40;
    txnDo(tsr_pkg::TSR_SEND_BYTE, 8'h0F, 8'h00);
    rd(8'h01, sm(-300));
    rdK(tsr_pkg::TSR_READ_BYTE, 8'h02, 9'h080, 9'h080);
    txnDo(tsr_pkg::TSR_SEND_BYTE, 8'h0F, 8'h00);
    repeat (60) @(posedge core_clk);
    check(9'(starts - s0), 9'h001);
    rdK(tsr_pkg::TSR_READ_BYTE, 8'h02, 9'h000, 9'h080);
    $display("standby conversions done");
    wr(8'h0D, 8'h7F);
    wr(8'h0E, 8'hC9);
    conv(0);
    rdK(tsr_pkg::TSR_READ_BYTE, 8'h02, 9'h000, 9'h000);
    rdK(tsr_pkg::TSR_ARA, 8'h00, 9'h000, 9'h000);
    repeat (2) @(posedge core_clk);
    check({8'h00, alertOe}, 9'h000);
    wr(8'h0D, 8'h28);
    conv(50);
    stat(8'h10);
    check({8'h00, alertOe}, 9'h001);
    stat(8'h10);
    wr(8'h09, 8'hC0);
    repeat (2) @(posedge core_clk);
    check({8'h00, alertOe}, 9'h001);
    rdK(tsr_pkg::TSR_ARA, 8'h00, 9'h000, 9'h100);
    wr(8'h0D, 8'h7F);
    wr(8'h0E, 8'h3C);
    conv(50);
    stat(8'h18);
    stat(8'h08);
    wr(8'h0E, 8'hC9);
    conv(50);
    stat(8'h08);
    stat(8'h00);
    wr(8'h09, 8'h40);
    rdK(tsr_pkg::TSR_ARA, 8'h00, 9'h16A, 9'h1FE);
    repeat (2) @(posedge core_clk);
    check({8'h00, alertOe}, 9'h000);
    openDiode <= 1'b1;
    repeat (8) @(posedge core_clk);
    check({8'h00, alertOe}, 9'h001);
    stat(8'h04);
    openDiode <= 1'b0;
    repeat (6) @(posedge core_clk);
    // Flag stays sticky until one read after the diode recovers
    stat(8'h04);
    stat(8'h00);
    rdK(tsr_pkg::TSR_ARA, 8'h00, 9'h16A, 9'h1FE);
    $display("alarms and alert done");
    // Prompt front end so each interval is set by the timer alone
    lag <= 8'd2;
    wr(8'h09, 8'h00);
    for (int c = 0; c < 9; c++) begin
      wr(8'h0A, 8'(c));
      n = TICK << (7 - ((c > 7) ? 2 : c));
      w = 0;
      while (convStart !== 1'b1 && w < 3 * n) begin
        @(posedge core_clk);
        w++;
      end
      @(posedge core_clk);
      w = 1;
      while (convStart !== 1'b1 && w < 3 * n) begin
        @(posedge core_clk);
        w++;
      end
      check(9'(w * 10 >= n * 7 && w * 10 <= n * 13), 9'h001);
    end
    $display("auto rates done");
    repeat (4) @(posedge core_clk);
    check(9'(expQ.size()), 9'h000);
    results();
  end
endmodule : tsr_thermal_regs_tb
`default_nettype wire
